// >>> src/rf_list_sequencer.sv
// Contract
// - Each list entry is one 32-bit word: 14-bit instruction, 18-bit data.
// - Nine instruction bits form the operation code.
// - Remaining five instruction bits pick the destination of the operation.
// - Operations include load amplitude, load phase and jump to address.
// - Operand comes from the 18-bit data part.
// - Start from timing controller runs chosen list, loading amplitude DAC.
// - Up to 256 start-address pointer registers select up to 256 lists.
// - Each list has a position pointer, incremented as execution advances.
// - Instruction memory is 64K or 256K words; addressing covers it.
// - Instruction timing comes from a local 20 MHz duration generator.
// - Consecutive instructions are at least 50 ns apart.
// - Durations programmable in 25 ns steps above the minimum.
// - Amplitude changes reach DAC within 100 ns, commanded ones within 250 ns.
// - Phase and frequency changes meet their stated latencies.
// - Amplitude and power DACs take 12-bit codes.
// - -6 to 20 dB: attenuators off, table codes 0x5 to 0x79A.
// - Channel number comes from the strap jumper, not the slot.
`timescale 1ns/1ps
`include "rf_list_sequencer_defines.svh"
module rf_list_sequencer (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [`RLS_BUS_AW-1:0] bus_addr_in,
  input wire logic [31:0] bus_wdata_in,
  input wire logic bus_write_in,
  input wire logic bus_read_in,
  output logic [31:0] bus_rdata_out,
  input wire logic pulse_timing_controller_start_n_in,
  input wire logic [`RLS_PTR_AW-1:0] list_select_in,
  input wire logic [`RLS_CHAN_W-1:0] channel_number_strap_in,
  output logic [`RLS_DAC_W-1:0] amplitude_shape_value_out,
  output logic [`RLS_DAC_W-1:0] power_scale_value_out,
  output logic coarse_attenuator_step_out,
  output logic fine_attenuator_step_out,
  output logic output_synthesizer_valid_out,
  input wire logic output_synthesizer_ready_in,
  output logic [`RLS_DEST_W-1:0] output_synthesizer_dest_out,
  output logic [`RLS_DATA_W-1:0] output_synthesizer_data_out,
  output logic running_out,
  output logic [`RLS_CHAN_W-1:0] channel_number_out
);
  // ----------------------------------------
  // Power setting to attenuators and code
  // ----------------------------------------
  // Returns {coarse, fine, code}; whole dB only, out-of-range clamps
  localparam logic [`RLS_PWR_TABLE_W-1:0] power_codes = {`RLS_PWR_CODES_HI, `RLS_PWR_CODES_LO};
  function automatic logic [13:0] power_map(input logic signed [7:0] db);
    logic signed [7:0] r;
    logic [1:0] att;
    logic [4:0] idx;
    begin
      r = (db > `RLS_PWR_MAX_DB) ? `RLS_PWR_MAX_DB :
          (db < `RLS_PWR_MIN_DB) ? `RLS_PWR_MIN_DB : db;
      att = (r > `RLS_PWR_R3_DB) ? 2'b11 : (r > `RLS_PWR_R2_DB) ? 2'b10 :
            (r > `RLS_PWR_R1_DB) ? 2'b01 : 2'b00;
      // Each 20 dB range reuses the same code progression
      idx = 5'(r - `RLS_PWR_MIN_DB - 8'(att) * `RLS_PWR_R1_DB);
      power_map = {att, power_codes[idx * `RLS_DAC_W +: `RLS_DAC_W]};
    end
  endfunction
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic start_meta_q, start_sync_q, start_prev_q;
  logic [`RLS_PTR_AW-1:0] sel_meta_q, sel_sync_q;
  logic [`RLS_CHAN_W-1:0] strap_meta_q, strap_sync_q, channel_q;
  logic [1:0] strap_age_q;
  logic strap_taken_q;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      start_meta_q <= 1'b1;
      start_sync_q <= 1'b1;
      start_prev_q <= 1'b1;
      sel_meta_q <= '0;
      sel_sync_q <= '0;
      strap_meta_q <= '0;
      strap_sync_q <= '0;
    end else begin
      start_meta_q <= pulse_timing_controller_start_n_in;
      start_sync_q <= start_meta_q;
      start_prev_q <= start_sync_q;
      sel_meta_q <= list_select_in;
      sel_sync_q <= sel_meta_q;
      strap_meta_q <= channel_number_strap_in;
      strap_sync_q <= strap_meta_q;
    end
  end
  // Strap is read once the synchroniser has settled after release
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_age_q <= '0;
      strap_taken_q <= 1'b0;
      channel_q <= '0;
    end else if (!strap_taken_q) begin
      strap_age_q <= 2'(strap_age_q + 1'b1);
      if (strap_age_q == `RLS_STRAP_WAIT) begin
        channel_q <= strap_sync_q;
        strap_taken_q <= 1'b1;
      end
    end
  end
  wire start_pulse = start_prev_q && !start_sync_q;
  // ----------------------------------------
  // Register bus decode
  // ----------------------------------------
  logic [1:0] ctrl_q;
  logic [`RLS_DATA_W-1:0] mem_addr_q;
  logic signed [7:0] power_db_q;
  wire wr_ctrl = bus_write_in && bus_addr_in == `RLS_REG_CTRL;
  wire wr_mem_addr = bus_write_in && bus_addr_in == `RLS_REG_MEM_ADDR;
  wire wr_mem_data = bus_write_in && bus_addr_in == `RLS_REG_MEM_DATA;
  wire wr_power = bus_write_in && bus_addr_in == `RLS_REG_POWER;
  wire wr_amp = bus_write_in && bus_addr_in == `RLS_REG_AMP;
  wire wr_synth = bus_write_in && bus_addr_in == `RLS_REG_SYNTH;
  wire wr_ptr = bus_write_in && bus_addr_in[11:10] == `RLS_PTR_REGION;
  wire [`RLS_PTR_AW-1:0] ptr_idx = bus_addr_in[9:2];
  wire enable = ctrl_q[`RLS_CTRL_ENABLE];
  wire resume = ctrl_q[`RLS_CTRL_RESUME];
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= '0;
      mem_addr_q <= '0;
      power_db_q <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= bus_wdata_in[1:0];
      end
      if (wr_mem_addr) begin
        mem_addr_q <= bus_wdata_in[`RLS_DATA_MSB:0];
      end else if (wr_mem_data) begin
        mem_addr_q <= `RLS_DATA_W'(mem_addr_q + 1'b1);
      end
      if (wr_power) begin
        power_db_q <= bus_wdata_in[7:0];
      end
    end
  end

  // ----------------------------------------
  // Memories
  // ----------------------------------------
  rf_list_sequencer_pkg::seq_state_t state_q, state_d;
  logic [`RLS_DATA_W-1:0] pos_q, pos_d;
  logic [`RLS_PTR_AW-1:0] list_q;
  logic [`RLS_WORD_W-1:0] word;
  logic [`RLS_DATA_W-1:0] start_addr, saved_pos;
  logic pos_we;
  rls_ram #(.W(`RLS_WORD_W), .AW(`RLS_IMEM_AW)) u_imem (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .we_in(wr_mem_data),
    .waddr_in(mem_addr_q[`RLS_IMEM_AW-1:0]),
    .wdata_in(bus_wdata_in),
    .raddr_in(pos_q[`RLS_IMEM_AW-1:0]),
    .rdata_out(word)
  );
  rls_ram #(.W(`RLS_DATA_W), .AW(`RLS_PTR_AW)) u_start_ptr (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .we_in(wr_ptr),
    .waddr_in(ptr_idx),
    .wdata_in(bus_wdata_in[`RLS_DATA_MSB:0]),
    .raddr_in(sel_sync_q),
    .rdata_out(start_addr)
  );
  rls_ram #(.W(`RLS_DATA_W), .AW(`RLS_PTR_AW)) u_position (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .we_in(pos_we),
    .waddr_in(list_q),
    .wdata_in(pos_d),
    .raddr_in(sel_sync_q),
    .rdata_out(saved_pos)
  );
  // ----------------------------------------
  // Word decode
  // ----------------------------------------
  wire [`RLS_OP_W-1:0] op = word[`RLS_OP_MSB:`RLS_OP_LSB];
  wire [`RLS_DEST_W-1:0] dest_field = word[`RLS_DEST_MSB:`RLS_DEST_LSB];
  wire [`RLS_DATA_W-1:0] operand = word[`RLS_DATA_MSB:0];
  wire op_load = op == `RLS_OP_LOAD;
  wire op_amp = op == `RLS_OP_LOAD_AMP;
  wire op_phase = op == `RLS_OP_LOAD_PHASE;
  wire op_jump = op == `RLS_OP_JUMP;
  wire op_delay = op == `RLS_OP_DELAY;
  wire op_end = op == `RLS_OP_END;
  wire is_load = op_load || op_amp || op_phase;
  wire [`RLS_DEST_W-1:0] load_dest = op_amp ? `RLS_DEST_AMP :
                                     op_phase ? `RLS_DEST_PHASE : dest_field;
  // ----------------------------------------
  // Output FIFO feed
  // ----------------------------------------
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [`RLS_FIFO_W-1:0] fifo_out_data;
  wire in_exec = state_q == rf_list_sequencer_pkg::S_EXEC;
  // Commanded writes win the FIFO port; the list waits a cycle instead
  wire seq_push = in_exec && is_load && !wr_synth;
  wire seq_stall = is_load && (wr_synth || !fifo_in_ready);
  wire [`RLS_FIFO_W-1:0] push_data = wr_synth ? bus_wdata_in[`RLS_FIFO_W-1:0] :
                                     {load_dest, operand};
  rls_fifo #(.W(`RLS_FIFO_W), .DEPTH(`RLS_FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(wr_synth || seq_push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(push_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_data)
  );
  // ----------------------------------------
  // Duration generator
  // ----------------------------------------
  // Restarted at each instruction so the minimum spacing is never shortened
  logic [5:0] acc_q;
  logic [`RLS_DATA_W:0] steps_q;
  wire [5:0] acc_sum = 6'(acc_q + 6'(`RLS_CLK_NS));
  wire step_tick = acc_sum >= 6'(`RLS_STEP_NS);
  wire [`RLS_DATA_W:0] dur_steps = (`RLS_DATA_W+1)'(`RLS_MIN_STEPS) +
                                   (op_delay ? {1'b0, operand} : '0);
  wire in_hold = state_q == rf_list_sequencer_pkg::S_HOLD;
  wire dur_done = in_hold && step_tick && steps_q == (`RLS_DATA_W+1)'(1);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_q <= '0;
      steps_q <= '0;
    end else if (in_exec) begin
      acc_q <= '0;
      steps_q <= dur_steps;
    end else begin
      acc_q <= step_tick ? 6'(acc_sum - 6'(`RLS_STEP_NS)) : acc_sum;
      steps_q <= (in_hold && step_tick) ? (`RLS_DATA_W+1)'(steps_q - 1'b1) : steps_q;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    pos_d = pos_q;
    pos_we = 1'b0;
    unique case (state_q)
      rf_list_sequencer_pkg::S_IDLE: begin
      end
      rf_list_sequencer_pkg::S_PTR: begin
        pos_d = resume ? saved_pos : start_addr;
        state_d = rf_list_sequencer_pkg::S_FETCH;
      end
      rf_list_sequencer_pkg::S_FETCH: begin
        state_d = rf_list_sequencer_pkg::S_EXEC;
      end
      rf_list_sequencer_pkg::S_EXEC: begin
        if (op_end) begin
          state_d = rf_list_sequencer_pkg::S_IDLE;
        end else if (!seq_stall) begin
          pos_d = op_jump ? operand : `RLS_DATA_W'(pos_q + 1'b1);
          pos_we = 1'b1;
          state_d = rf_list_sequencer_pkg::S_HOLD;
        end
      end
      rf_list_sequencer_pkg::S_HOLD: begin
        if (dur_done) begin
          state_d = rf_list_sequencer_pkg::S_FETCH;
        end
      end
    endcase
    if (!enable) begin
      state_d = rf_list_sequencer_pkg::S_IDLE;
    end else if (start_pulse) begin
      state_d = rf_list_sequencer_pkg::S_PTR;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= rf_list_sequencer_pkg::S_IDLE;
      pos_q <= '0;
      list_q <= '0;
    end else begin
      state_q <= state_d;
      pos_q <= pos_d;
      list_q <= (enable && start_pulse) ? sel_sync_q : list_q;
    end
  end

  // ----------------------------------------
  // Destination update
  // ----------------------------------------
  wire [`RLS_DEST_W-1:0] out_dest = fifo_out_data[`RLS_FIFO_W-1:`RLS_DATA_W];
  wire [`RLS_DATA_W-1:0] out_val = fifo_out_data[`RLS_DATA_MSB:0];
  wire out_local = out_dest == `RLS_DEST_AMP || out_dest == `RLS_DEST_SCALE ||
                   out_dest == `RLS_DEST_ATTEN || out_dest == `RLS_DEST_POWER_DB;
  // Synthesizer back-pressure stalls the FIFO and so the list
  assign fifo_out_ready = out_local || output_synthesizer_ready_in;
  wire pop_local = fifo_out_valid && out_local;
  wire [13:0] bus_power = power_map(power_db_q);
  wire [13:0] list_power = power_map(out_val[7:0]);
  logic [`RLS_DAC_W-1:0] amp_q, scale_q;
  logic [1:0] att_q;
  logic power_load_q;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      amp_q <= '0;
      scale_q <= 12'h400;
      att_q <= 2'b00;
      power_load_q <= 1'b0;
    end else begin
      power_load_q <= wr_power;
      if (wr_amp) begin
        amp_q <= bus_wdata_in[`RLS_DAC_W-1:0];
      end else if (pop_local && out_dest == `RLS_DEST_AMP) begin
        amp_q <= out_val[`RLS_DAC_W-1:0];
      end
      if (power_load_q) begin
        {att_q, scale_q} <= bus_power;
      end else if (pop_local && out_dest == `RLS_DEST_POWER_DB) begin
        {att_q, scale_q} <= list_power;
      end else if (pop_local && out_dest == `RLS_DEST_SCALE) begin
        scale_q <= out_val[`RLS_DAC_W-1:0];
      end else if (pop_local && out_dest == `RLS_DEST_ATTEN) begin
        att_q <= out_val[1:0];
      end
    end
  end

  assign amplitude_shape_value_out = amp_q;
  assign power_scale_value_out = scale_q;
  assign coarse_attenuator_step_out = att_q[1];
  assign fine_attenuator_step_out = att_q[0];
  assign output_synthesizer_valid_out = fifo_out_valid && !out_local;
  assign output_synthesizer_dest_out = out_dest;
  assign output_synthesizer_data_out = out_val;
  assign running_out = state_q != rf_list_sequencer_pkg::S_IDLE;
  assign channel_number_out = channel_q;
  // ----------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------
  logic [31:0] rdata_d;
  always_comb begin
    unique case (bus_addr_in)
      `RLS_REG_CTRL: rdata_d = {30'h0, ctrl_q};
      `RLS_REG_STATUS: rdata_d = {16'h0, channel_q, list_q, 2'b00, !fifo_in_ready, running_out};
      `RLS_REG_MEM_ADDR: rdata_d = {14'h0, mem_addr_q};
      `RLS_REG_POWER: rdata_d = {24'h0, power_db_q};
      `RLS_REG_AMP: rdata_d = {20'h0, amp_q};
      `RLS_REG_POSITION: rdata_d = {14'h0, pos_q};
      default: rdata_d = '0;
    endcase
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_rdata_out <= '0;
    end else begin
      bus_rdata_out <= bus_read_in ? rdata_d : '0;
    end
  end

endmodule // rf_list_sequencer

// >>> inc/rf_list_sequencer_defines.svh
`ifndef RF_LIST_SEQUENCER_DEFINES_SVH
`define RF_LIST_SEQUENCER_DEFINES_SVH

// ----------------------------------------
// List word layout
// ----------------------------------------
`define RLS_WORD_W 32
`define RLS_DATA_W 18
`define RLS_DATA_MSB 17
`define RLS_DEST_W 5
`define RLS_DEST_LSB 18
`define RLS_DEST_MSB 22
`define RLS_OP_W 9
`define RLS_OP_LSB 23
`define RLS_OP_MSB 31
// Standard build; the optional build uses 18
`define RLS_IMEM_AW 16
`define RLS_PTR_AW 8
`define RLS_DAC_W 12
`define RLS_CHAN_W 4

// ----------------------------------------
// Operation and destination codes
// ----------------------------------------
`define RLS_OP_END 9'h000
`define RLS_OP_LOAD 9'h001
`define RLS_OP_LOAD_AMP 9'h002
`define RLS_OP_LOAD_PHASE 9'h003
`define RLS_OP_JUMP 9'h004
`define RLS_OP_DELAY 9'h005
`define RLS_DEST_AMP 5'h00
`define RLS_DEST_SCALE 5'h01
`define RLS_DEST_PHASE 5'h02
`define RLS_DEST_FREQ 5'h03
`define RLS_DEST_ATTEN 5'h04
`define RLS_DEST_POWER_DB 5'h05

// ----------------------------------------
// Register map
// ----------------------------------------
`define RLS_BUS_AW 12
`define RLS_REG_CTRL 12'h000
`define RLS_REG_STATUS 12'h004
`define RLS_REG_MEM_ADDR 12'h008
`define RLS_REG_MEM_DATA 12'h00c
`define RLS_REG_POWER 12'h010
`define RLS_REG_AMP 12'h014
`define RLS_REG_SYNTH 12'h018
`define RLS_REG_POSITION 12'h01c
`define RLS_PTR_REGION 2'h1
`define RLS_CTRL_ENABLE 0
`define RLS_CTRL_RESUME 1

// ----------------------------------------
// Timing and buffering
// ----------------------------------------
`define RLS_CLK_NS 8
`define RLS_DUR_GEN_MHZ 20
`define RLS_STEP_NS (1000 / (2 * `RLS_DUR_GEN_MHZ))
`define RLS_MIN_DUR_NS 50
`define RLS_MIN_STEPS (`RLS_MIN_DUR_NS / `RLS_STEP_NS)
`define RLS_FIFO_DEPTH 8
`define RLS_FIFO_W 23
`define RLS_STRAP_WAIT 2'h3

// ----------------------------------------
// Power ranges in dB
// ----------------------------------------
`define RLS_PWR_MIN_DB 8'shfa
`define RLS_PWR_MAX_DB 8'sh50
`define RLS_PWR_R1_DB 8'sh14
`define RLS_PWR_R2_DB 8'sh28
`define RLS_PWR_R3_DB 8'sh3c
`define RLS_PWR_TABLE_W 324
`define RLS_PWR_CODES_HI 180'h79a78d77f76f75e_74a73471b6ff6df_6bc6956686375f5
`define RLS_PWR_CODES_LO 144'h5c057a52b4d346f400_3832f725a1a90e3005

`endif

// >>> inc/rf_list_sequencer_pkg.sv
package rf_list_sequencer_pkg;

  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_PTR   = 5'b00010,
    S_FETCH = 5'b00100,
    S_EXEC  = 5'b01000,
    S_HOLD  = 5'b10000
  } seq_state_t;

endpackage

// >>> src/rls_storage.sv
`timescale 1ns/1ps

// ----------------------------------------
// Single-port-write RAM, registered read
// ----------------------------------------
module rls_ram #(
  parameter int W = 32,
  parameter int AW = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [W-1:0] wdata_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [W-1:0] rdata_out
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= mem[raddr_in];
    end
  end
endmodule // rls_ram

// ----------------------------------------
// Word FIFO with valid/ready on both sides
// ----------------------------------------
module rls_fifo #(
  parameter int W = 23,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [0:DEPTH-1];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] count_q;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;

  assign in_ready_out = count_q != (PW+1)'(DEPTH);
  assign out_valid_out = count_q != '0;
  assign out_data_out = mem[rd_q];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else begin
      wr_q <= push ? PW'(wr_q + 1'b1) : wr_q;
      rd_q <= pop ? PW'(rd_q + 1'b1) : rd_q;
      count_q <= (PW+1)'(count_q + {PW'(0), push} - {PW'(0), pop});
    end
  end
endmodule // rls_fifo

// >>> tb/rls_checker_sva.sv
`timescale 1ns/1ps
`include "rf_list_sequencer_defines.svh"

module rls_checker (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [11:0] bus_addr_in,
  input wire logic [31:0] bus_wdata_in,
  input wire logic bus_write_in,
  input wire logic [3:0] channel_number_strap_in,
  input wire logic [11:0] amplitude_shape_value_out,
  input wire logic [11:0] power_scale_value_out,
  input wire logic coarse_attenuator_step_out,
  input wire logic fine_attenuator_step_out,
  input wire logic output_synthesizer_valid_out,
  input wire logic output_synthesizer_ready_in,
  input wire logic [4:0] output_synthesizer_dest_out,
  input wire logic [17:0] output_synthesizer_data_out,
  input wire logic running_out,
  input wire logic [3:0] channel_number_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // ----
  // Age since reset, cycles since amplitude moved
  // ----
  logic [2:0] age_q;
  logic [3:0] gap_q;
  logic [11:0] last_q;
  wire [7:0] db = bus_wdata_in[7:0];
  wire pw_wr = bus_write_in && bus_addr_in == `RLS_REG_POWER;
  wire amp_wr = bus_write_in && bus_addr_in == `RLS_REG_AMP;
  wire moved = amplitude_shape_value_out != last_q;
  wire [1:0] att = {coarse_attenuator_step_out, fine_attenuator_step_out};
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      age_q <= 3'h0;
      gap_q <= 4'hf;
      last_q <= 12'h000;
    end else begin
      age_q <= age_q + {2'h0, age_q != 3'h7};
      gap_q <= moved ? 4'h0 : gap_q + {3'h0, gap_q != 4'hf};
      last_q <= amplitude_shape_value_out;
    end
  end
  a_amp_write_direct: assert property (
    amp_wr |=> amplitude_shape_value_out == $past(bus_wdata_in[11:0]))
    else $error("amplitude write lost");
  a_power_floor: assert property (
    pw_wr && db == 8'hfa |-> ##2 power_scale_value_out == 12'h005 && att == 2'b00)
    else $error("power floor code wrong");
  a_power_unity: assert property (
    pw_wr && db == 8'h00 |-> ##2 power_scale_value_out == 12'h400 && att == 2'b00)
    else $error("power unity code wrong");
  a_power_top_code: assert property (
    pw_wr && db == 8'h14 |-> ##2 power_scale_value_out == 12'h79a && att == 2'b00)
    else $error("power top code wrong");
  a_power_fine_range: assert property (
    pw_wr && db == 8'h1e |-> ##2 power_scale_value_out == 12'h6bc && att == 2'b01)
    else $error("fine step range wrong");
  a_strap_capture: assert property (
    age_q == 3'h6 |-> channel_number_out == channel_number_strap_in)
    else $error("channel not from strap");
  a_synth_hold: assert property (
    output_synthesizer_valid_out && !output_synthesizer_ready_in |=> output_synthesizer_valid_out
    && $stable(output_synthesizer_dest_out) && $stable(output_synthesizer_data_out))
    else $error("synth word dropped while stalled");
  // Bus amplitude writes may land any time, so only list loads are spaced
  a_amp_spacing: assert property (
    moved && running_out && !$past(amp_wr) |-> gap_q >= 4'h6)
    else $error("list amplitude steps too close");
endmodule // rls_checker

bind rf_list_sequencer rls_checker i_rls_checker (
  .clk_in, .rst_in, .bus_addr_in, .bus_wdata_in, .bus_write_in, .channel_number_strap_in,
  .amplitude_shape_value_out, .power_scale_value_out, .coarse_attenuator_step_out,
  .fine_attenuator_step_out, .output_synthesizer_valid_out, .output_synthesizer_ready_in,
  .output_synthesizer_dest_out, .output_synthesizer_data_out, .running_out, .channel_number_out
);

// >>> tb/pulse_timing_controller_model.sv
`timescale 1ns/1ps

// ----
// Start pin and list select
// ----
module pulse_timing_controller_model (
  input wire logic clk_in,
  output logic start_n_out,
  output logic [7:0] list_select_out
);
  initial begin
    start_n_out = 1'b1;
    list_select_out = 8'h00;
  end
  // Select settles first since the pin is synced; low_cycles sets how long the pin stays low
  task automatic start_list(input logic [7:0] num, input int low_cycles);
    @(posedge clk_in);
    list_select_out <= num;
    repeat (4) @(posedge clk_in);
    start_n_out <= 1'b0;
    repeat (low_cycles) @(posedge clk_in);
    start_n_out <= 1'b1;
  endtask
endmodule // pulse_timing_controller_model

// >>> tb/tb.sv
`timescale 1ns/1ps
`include "rf_list_sequencer_defines.svh"

module tb;
  logic clk_in, rst_in, wr_en, rd_en, syn_ready, start_n, start_prev;
  logic coarse, fine, syn_valid, running;
  logic [11:0] addr, amp, scale, a1;
  logic [31:0] wdata, rdata, rd, v;
  logic [3:0] strap, chan;
  logic [4:0] syn_dest;
  logic [17:0] syn_data, base;
  logic [7:0] sel;
  logic [31:0] prog [7];
  logic [22:0] q [$];
  int seed = 61;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int fall_cyc = 0;
  int t1, t2, t3, db;
  int corner [8] = '{-9, -6, 0, 20, 21, 30, 41, 90};

  rf_list_sequencer i_rf_list_sequencer (
    .clk_in(clk_in), .rst_in(rst_in), .bus_addr_in(addr), .bus_wdata_in(wdata),
    .bus_write_in(wr_en), .bus_read_in(rd_en), .bus_rdata_out(rdata),
    .pulse_timing_controller_start_n_in(start_n), .list_select_in(sel),
    .channel_number_strap_in(strap), .amplitude_shape_value_out(amp),
    .power_scale_value_out(scale), .coarse_attenuator_step_out(coarse),
    .fine_attenuator_step_out(fine), .output_synthesizer_valid_out(syn_valid),
    .output_synthesizer_ready_in(syn_ready), .output_synthesizer_dest_out(syn_dest),
    .output_synthesizer_data_out(syn_data), .running_out(running), .channel_number_out(chan));
  pulse_timing_controller_model i_pulse_timing_controller_model (
    .clk_in(clk_in), .start_n_out(start_n), .list_select_out(sel));

  // ----
  // Clock, bus tasks, expectations
  // ----
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    start_prev <= start_n;
    if (start_prev && !start_n) begin
      fall_cyc <= cyc;
    end
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task end_of_test;
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_in);
    wr_en <= 1'b0;
    #1;
  endtask
  task rdr(input logic [11:0] a);
    @(posedge clk_in);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_in);
    rd_en <= 1'b0;
    #1;
    rd = rdata;
  endtask
  task do_reset(input logic [3:0] s);
    @(posedge clk_in);
    rst_in <= 1'b1;
    strap <= s;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    #1;
    chk("channel", s, chan);
  endtask
  task automatic wait_amp(input logic [11:0] exp, output int at);
    logic [11:0] prev;
    int n;
    prev = amp;
    n = 0;
    while (amp === prev && n < 300) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    at = cyc;
    chk("amp_list", exp, amp);
  endtask
  function automatic logic [13:0] pw(input int d);
    logic [`RLS_PWR_TABLE_W-1:0] t = {`RLS_PWR_CODES_HI, `RLS_PWR_CODES_LO};
    int r, a;
    r = d < -6 ? -6 : (d > 80 ? 80 : d);
    a = (r - 1) / 20;
    return {2'(a), t[(r + 6 - 20 * a) * 12 +: 12]};
  endfunction
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    end_of_test;
  end
  initial begin
    rst_in = 1'b1;
    {wr_en, rd_en, addr, wdata, strap} = '0;
    syn_ready = 1'b1;
    start_prev = 1'b1;
    v = $random(seed);
    do_reset(v[3:0]);
    chk("scale_reset", 12'h400, scale);
    rdr(`RLS_REG_STATUS);
    chk("status_chan", strap, rd[15:12]);
    rdr(12'h020);
    chk("unmapped", 0, rd);
    for (int i = 0; i < 24; i++) begin
      db = (i < 8) ? corner[i] : $random(seed) % 100;
      wr(`RLS_REG_POWER, {24'h0, db[7:0]});
      repeat (2) @(posedge clk_in);
      #1;
      chk("power", pw(db), {coarse, fine, scale});
    end
    v = $random(seed);
    wr(`RLS_REG_AMP, v);
    chk("amp_direct", v[11:0], amp);
    rdr(`RLS_REG_AMP);
    chk("amp_read", v[11:0], rd[11:0]);
    wr(`RLS_REG_AMP, 0);
    @(posedge clk_in);
    syn_ready <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      v = $random(seed);
      v[22:18] = 5'h06 + 5'(i);
      wr(`RLS_REG_SYNTH, {9'h0, v[22:0]});
      if (i < 8) q.push_back(v[22:0]);
    end
    rdr(`RLS_REG_STATUS);
    chk("fifo_full", 1, rd[1]);
    v = $random(seed);
    for (int n = 0; n < 40; n++) begin
      @(posedge clk_in);
      syn_ready <= v[n % 32] || n > 30;
      @(negedge clk_in);
      if (syn_valid === 1'b1 && syn_ready === 1'b1) begin
        chk("synth_word", q.pop_front(), {syn_dest, syn_data});
      end
    end
    chk("synth_left", 0, q.size());
    v = $random(seed);
    base = {2'b00, v[15:4], 4'h0};
    a1 = {1'b1, v[26:16]};
    prog = '{{`RLS_OP_LOAD_AMP, `RLS_DEST_AMP, 6'h0, a1}, {`RLS_OP_DELAY, 20'h0, v[29:27]},
      {`RLS_OP_LOAD_AMP, `RLS_DEST_AMP, 6'h0, ~a1}, {`RLS_OP_JUMP, `RLS_DEST_AMP, base + 18'h5},
      {`RLS_OP_LOAD_AMP, 23'h0}, {`RLS_OP_LOAD_AMP, `RLS_DEST_AMP, 6'h0, a1 ^ 12'h555}, 32'h0};
    wr(12'h400 + {2'b0, v[7:0], 2'b0}, {14'h0, base});
    rdr(12'h400 + {2'b0, v[7:0], 2'b0});
    chk("ptr_read", 0, rd);
    wr(`RLS_REG_MEM_ADDR, {14'h0, base});
    foreach (prog[k]) wr(`RLS_REG_MEM_DATA, prog[k]);
    i_pulse_timing_controller_model.start_list(v[7:0], 1);
    repeat (20) @(posedge clk_in);
    #1;
    chk("start_off", 0, running);
    wr(`RLS_REG_CTRL, 1);
    fork
      i_pulse_timing_controller_model.start_list(v[7:0], 3);
      begin
        wait_amp(a1, t1);
        wait_amp(~a1, t2);
        wait_amp(a1 ^ 12'h555, t3);
      end
    join
    chk("start_time", 1, (t1 - fall_cyc) * 8 <= 250);
    chk("delay_time", 1, (t2 - t1) * 8 >= (4 + v[29:27]) * 25);
    chk("min_gap", 1, (t3 - t2) * 8 >= 50);
    for (int n = 0; n < 100 && running === 1'b1; n++) @(posedge clk_in);
    #1;
    chk("list_done", 0, running);
    chk("jump_skip", a1 ^ 12'h555, amp);
    v = $random(seed);
    do_reset(v[3:0]);
    @(posedge clk_in);
    strap <= ~v[3:0];
    repeat (4) @(posedge clk_in);
    #1;
    chk("strap_once", v[3:0], chan);
    end_of_test;
  end
endmodule // tb
